// ---- nand_host.sv ----
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.svh"
module nand_host
  import nand_host_pkg::*;
#(
  parameter logic [15:0] ARRAY_READ_CYC = `ARRAY_READ_CYC
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Memory pins
  output nand_out_s        pins,
  input  wire logic [7:0]  io_bus_in,
  input  wire logic        ready_busy_n
);

  host_s      st;
  host_s      next_st;
  logic [8:0] synced;
  logic       ready;
  logic       start;
  logic [31:0] rd_word;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  nand_pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({ready_busy_n, io_bus_in}),
    .q       (synced)
  );

  // Open-drain ready line, pulled up outside
  assign ready = synced[8];

  // Address byte for cycle index; upper unused bits stay low
  function automatic logic [7:0] addr_byte(input logic [2:0]  i,
                                           input logic [12:0] c,
                                           input logic [19:0] r);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      3'h0:    b = c[7:0];
      3'h1:    b = {3'h0, c[12:8]};
      3'h2:    b = r[7:0];
      3'h3:    b = r[15:8];
      default: b = {4'h0, r[19:16]};
    endcase
    return b;
  endfunction

  // Column-only and row-only forms serve 05h/85h and 60h sequences
  function automatic logic [2:0] first_idx(input op_e k);
    return (k == OP_ADDR3) ? 3'h2 : 3'h0;
  endfunction

  function automatic logic [2:0] last_idx(input op_e k);
    logic [2:0] v;
    v = 3'h0;
    if (k == OP_ADDR2) begin
      v = 3'h1;
    end else if (k == OP_ADDR5 || k == OP_ADDR3) begin
      v = 3'h4;
    end
    return v;
  endfunction

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      `REG_CTRL: begin
        rd_word[`CTRL_WP_BIT]    = st.wp_release;
        rd_word[`CTRL_DESEL_BIT] = st.deselect;
      end
      `REG_COL:  rd_word[12:0] = st.col;
      `REG_ROW:  rd_word[19:0] = st.row;
      `REG_OP: begin
        rd_word[7:0]                       = st.opbyte;
        rd_word[`OP_KIND_MSB:`OP_KIND_LSB] = st.kind;
        rd_word[`OP_WAIT_BIT]              = st.op_wait;
      end
      `REG_STATUS: begin
        rd_word[`ST_BUSY_BIT]    = (st.state != S_IDLE);
        rd_word[`ST_READY_BIT]   = ready;
        rd_word[`ST_STANDBY_BIT] = st.standby;
        rd_word[`ST_TIMEOUT_BIT] = st.timeout;
      end
      `REG_RDATA: rd_word[7:0] = st.rdata;
      default:    rd_word = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    start   = 1'b0;
    // Zero-wait slave: read data in the cycle after the address phase
    next_st.hreadyout = 1'b1;
    next_st.hresp     = 1'b0;
    next_st.wr_pend   = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[7:0];
      if (!hwrite) begin
        next_st.hrdata = rd_word;
      end
    end

    // Write data phase; an operation written while busy is dropped
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        `REG_CTRL: begin
          next_st.wp_release = hwdata[`CTRL_WP_BIT];
          next_st.deselect   = hwdata[`CTRL_DESEL_BIT];
        end
        `REG_COL: next_st.col = hwdata[12:0];
        // Page order and single programming are left to software
        `REG_ROW: next_st.row = hwdata[19:0];
        `REG_OP: begin
          if (st.state == S_IDLE &&
              op_e'(hwdata[`OP_KIND_MSB:`OP_KIND_LSB]) != OP_NONE) begin
            next_st.kind    = op_e'(hwdata[`OP_KIND_MSB:`OP_KIND_LSB]);
            next_st.opbyte  = hwdata[7:0];
            next_st.op_wait = hwdata[`OP_WAIT_BIT];
            start           = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Write protect follows software at all times
    next_st.pins.write_protect_n = next_st.wp_release;

    // Sequencer: one pin-level operation per software order
    unique case (st.state)
      S_IDLE: begin
        next_st.pins.chip_sel_n = st.deselect;
        if (start) begin
          next_st.timeout         = 1'b0;
          next_st.pins.chip_sel_n = 1'b0;
          if (next_st.kind == OP_DOUT) begin
            // Extra low time covers the synchroniser delay
            next_st.pins.io_bus_oe     = 1'b0;
            next_st.pins.read_strobe_n = 1'b0;
            next_st.cnt   = `RE_LO_CYC + `SYNC_LAT - 16'h0001;
            next_st.state = S_RE_LO;
          end else begin
            next_st.idx                 = first_idx(next_st.kind);
            next_st.pins.cmd_latch      = (next_st.kind == OP_CMD);
            next_st.pins.addr_latch     = (next_st.kind != OP_CMD &&
                                           next_st.kind != OP_DIN);
            next_st.pins.io_bus         = (next_st.kind == OP_ADDR5 ||
                                           next_st.kind == OP_ADDR2 ||
                                           next_st.kind == OP_ADDR3) ?
                                          addr_byte(first_idx(next_st.kind),
                                                    st.col, st.row) :
                                          next_st.opbyte;
            next_st.pins.io_bus_oe      = 1'b1;
            next_st.pins.write_strobe_n = 1'b0;
            next_st.cnt                 = `WE_LO_CYC - 16'h0001;
            next_st.state               = S_WE_LO;
          end
        end
      end
      S_WE_LO: begin
        if (st.cnt == 16'h0000) begin
          next_st.pins.write_strobe_n = 1'b1; // Rising edge latches byte
          next_st.cnt                 = `WE_HI_CYC - 16'h0001;
          next_st.state               = S_WE_HI;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      S_WE_HI: begin
        if (st.cnt != 16'h0000) begin
          next_st.cnt = st.cnt - 16'h0001;
        end else if (st.pins.addr_latch && st.idx != last_idx(st.kind)) begin
          // Next address cycle, lowest byte first
          next_st.idx                 = st.idx + 3'h1;
          next_st.pins.io_bus         = addr_byte(st.idx + 3'h1,
                                                  st.col, st.row);
          next_st.pins.write_strobe_n = 1'b0;
          next_st.cnt                 = `WE_LO_CYC - 16'h0001;
          next_st.state               = S_WE_LO;
        end else begin
          next_st.pins.cmd_latch  = 1'b0;
          next_st.pins.addr_latch = 1'b0;
          next_st.pins.io_bus_oe  = 1'b0;
          if (st.kind == OP_CMD && st.op_wait) begin
            // Busy may take a while to show after a confirm
            next_st.cnt   = `WB_CYC - 16'h0001;
            next_st.state = S_WB;
          end else begin
            next_st.state = S_IDLE;
          end
        end
      end
      S_RE_LO: begin
        if (st.cnt == 16'h0000) begin
          next_st.rdata              = synced[7:0];
          next_st.pins.read_strobe_n = 1'b1;
          next_st.cnt                = `RE_HI_CYC - 16'h0001;
          next_st.state              = S_RE_HI;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      S_RE_HI: begin
        if (st.cnt == 16'h0000) begin
          next_st.state = S_IDLE;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      S_WB: begin
        if (st.cnt == 16'h0000) begin
          next_st.cnt   = ARRAY_READ_CYC;
          next_st.state = S_RB;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      S_RB: begin
        if (ready) begin
          next_st.state = S_IDLE;
        end else if (st.cnt == 16'h0000) begin
          next_st.timeout = 1'b1; // Stuck busy gives up, sticky flag
          next_st.state   = S_IDLE;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    // Standby is reported once chip select has stayed high long enough
    if (st.pins.chip_sel_n) begin
      if (st.sb_cnt != `STANDBY_CYC) begin
        next_st.sb_cnt = st.sb_cnt + 16'h0001;
      end
      next_st.standby = (st.sb_cnt == `STANDBY_CYC);
    end else begin
      next_st.sb_cnt  = 16'h0000;
      next_st.standby = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st                      <= '0;
      st.kind                 <= OP_NONE;
      st.wp_release           <= `CTRL_WP_RST;
      st.deselect             <= `CTRL_DESEL_RST;
      st.pins.chip_sel_n      <= 1'b1;
      st.pins.write_strobe_n  <= 1'b1;
      st.pins.read_strobe_n   <= 1'b1;
      st.hreadyout            <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata    = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp     = st.hresp;
  assign pins      = st.pins;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Independent count of chip-select high time
  logic [15:0] ce_high;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_high <= 16'h0000;
    end else if (!st.pins.chip_sel_n) begin
      ce_high <= 16'h0000;
    end else if (ce_high != 16'hFFFF) begin
      ce_high <= ce_high + 16'h0001;
    end
  end

  a_cmd_strobes: assert property (
    !st.pins.write_strobe_n && st.pins.cmd_latch |->
      !st.pins.addr_latch && st.pins.read_strobe_n && !st.pins.chip_sel_n)
    else $error("command cycle strobes wrong");
  a_addr_strobes: assert property (
    !st.pins.write_strobe_n && st.pins.addr_latch |->
      !st.pins.cmd_latch && st.pins.read_strobe_n && !st.pins.chip_sel_n)
    else $error("address cycle strobes wrong");
  a_din_strobes: assert property (
    !st.pins.write_strobe_n && !st.pins.cmd_latch && !st.pins.addr_latch
      |-> st.pins.read_strobe_n && st.pins.write_protect_n)
    else $error("data-in cycle strobes wrong");
  a_dout_strobes: assert property (
    !st.pins.read_strobe_n |-> st.pins.write_strobe_n &&
      !st.pins.cmd_latch && !st.pins.addr_latch && !st.pins.io_bus_oe)
    else $error("data-out cycle strobes wrong");
  a_we_pulse: assert property (
    $fell(st.pins.write_strobe_n) |->
      !st.pins.write_strobe_n [*3] ##1 st.pins.write_strobe_n [*2])
    else $error("write strobe pulse timing wrong");
  a_re_cycle: assert property (
    $fell(st.pins.read_strobe_n) |->
      !st.pins.read_strobe_n [*5] ##1 st.pins.read_strobe_n [*2])
    else $error("read strobe cycle shorter than allowed");
  a_addr_five: assert property (
    $rose(st.pins.write_strobe_n) && st.kind == OP_ADDR5 &&
      st.idx == 3'h4 |-> st.pins.io_bus[7:4] == 4'h0 ##2 st.state == S_IDLE)
    else $error("fifth address cycle wrong");
  a_standby_time: assert property (
    $rose(st.standby) |-> ce_high > 16'd2000 && st.pins.chip_sel_n)
    else $error("standby flagged too early");
  a_busy_release: assert property (
    st.state == S_RB && ready |=> st.state == S_IDLE && !st.timeout)
    else $error("ready not seen after busy");

  c_standby:  cover property ($rose(st.standby));
  c_busy_end: cover property (st.state == S_RB ##1 st.state == S_IDLE);
  c_addr5:    cover property (st.kind == OP_ADDR5 && st.idx == 3'h4);
  c_read:     cover property ($rose(st.pins.read_strobe_n));

endmodule
`default_nettype wire

// ---- nand_host_regs.svh ----
// Contract
// - Five address bytes, unused upper bits low
// - Command byte latched on write strobe rise
// - Address byte latched likewise, five per address
// - Data byte needs write protect high
// - Read strobe pulses shift out one byte
// - Host holds write protect high when modifying; here the pin just follows the CTRL write-protect bit set by software
// - Chip select high 10 us means standby
// - Page read 00h, address, 30h, busy wait
// - Random output 05h, two columns, E0h
// - Multi-plane read 60h rows twice, 30h
// - Host reads each plane with 00h/05h/E0h
// - Program 80h, address, data, then 10h
// - Host programs pages once, ascending order; the controller does not enforce this, it is left to software
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define REG_CTRL    8'h00
`define REG_COL     8'h04
`define REG_ROW     8'h08
`define REG_OP      8'h0C
`define REG_STATUS  8'h10
`define REG_RDATA   8'h14

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_WP_BIT     0
`define CTRL_DESEL_BIT  1
`define CTRL_WP_RST     1'b0
`define CTRL_DESEL_RST  1'b1
`define OP_KIND_LSB     8
`define OP_KIND_MSB     10
`define OP_WAIT_BIT     12
`define ST_BUSY_BIT     0
`define ST_READY_BIT    1
`define ST_STANDBY_BIT  2
`define ST_TIMEOUT_BIT  3

// ****************************************
// Timing, in ns, and derived clock counts
// ****************************************
`define CLK_NS          16'h0005
`define T_WE_LO_NS      16'h000F
`define T_WE_HI_NS      16'h000A
`define T_RE_LO_NS      16'h000F
`define T_RE_HI_NS      16'h000A
`define T_WB_NS         16'h0064
`define T_STANDBY_NS    16'h2710
`define T_ARRAY_NS      16'hEA60
`define SYNC_LAT        16'h0002
`define CYC(t)          (((t) + `CLK_NS - 16'h0001) / `CLK_NS)
`define WE_LO_CYC       `CYC(`T_WE_LO_NS)
`define WE_HI_CYC       `CYC(`T_WE_HI_NS)
`define RE_LO_CYC       `CYC(`T_RE_LO_NS)
`define RE_HI_CYC       `CYC(`T_RE_HI_NS)
`define WB_CYC          `CYC(`T_WB_NS)
`define STANDBY_CYC     `CYC(`T_STANDBY_NS)
`define ARRAY_READ_CYC  `CYC(`T_ARRAY_NS)

`endif

// ---- nand_host_pkg.sv ----
`default_nettype none
package nand_host_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_WE_LO, S_WE_HI, S_RE_LO, S_RE_HI, S_WB, S_RB
  } seq_e;

  // Pin-level operations; OP_NONE is refused
  typedef enum logic [2:0] {
    OP_CMD, OP_ADDR, OP_ADDR5, OP_ADDR2, OP_ADDR3, OP_DIN, OP_DOUT, OP_NONE
  } op_e;

  // Pins driven towards the memory
  typedef struct packed {
    logic       cmd_latch;
    logic       addr_latch;
    logic       chip_sel_n;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       write_protect_n;
    logic [7:0] io_bus;
    logic       io_bus_oe;
  } nand_out_s;

  // Two-stage synchroniser state
  typedef struct packed {
    logic [8:0] meta;
    logic [8:0] stable;
  } pin_sync_s;

  // Whole state of the controller
  typedef struct packed {
    seq_e        state;
    logic [15:0] cnt;
    logic [2:0]  idx;
    op_e         kind;
    logic [7:0]  opbyte;
    logic        op_wait;
    nand_out_s   pins;
    logic [12:0] col;
    logic [19:0] row;
    logic        wp_release;
    logic        deselect;
    logic [7:0]  rdata;
    logic        timeout;
    logic [15:0] sb_cnt;
    logic        standby;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        wr_pend;
    logic [7:0]  wr_addr;
  } host_s;

endpackage
`default_nettype wire

// ---- nand_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module nand_pin_sync
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Raw pins in, synchronised levels out
  input  wire logic [8:0] d,
  output logic      [8:0] q
);

  pin_sync_s st;
  pin_sync_s next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

endmodule
`default_nettype wire

// ---- nand_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nand_mem_model
  import nand_host_pkg::*;
#(
  parameter int T_READ_NS = 500,
  parameter int T_PROG_NS = 300
)(
  // Strobes and bus from the host
  input  wire nand_out_s  pins,
  // Byte back to the host and busy pull-down
  output logic      [7:0] io_out,
  output logic            busy_pull
);
  // ****************************************
  // Page, program buffer and data register
  // ****************************************
  logic [7:0]  arr  [16];
  logic [7:0]  pbuf [16];
  logic [7:0]  dreg [16];
  logic [7:0]  last;
  logic [12:0] col;
  logic [19:0] row;
  logic        stat;
  logic        loaded;
  int          na, slow_ns, busy_cnt, bad_hi, fast_re, busy_t, reprog;
  logic [19:0] prog_row;
  logic        progd;
  realtime     t_fall;

  // Power-up state: page read mode, ready, bus released
  initial begin
    stat = 1'b0;
    loaded = 1'b0;
    busy_pull = 1'b0;
    last = 8'h00;
    io_out = 8'hFF;
    {na, slow_ns, busy_cnt, bad_hi, fast_re, reprog} = '0;
    progd = 1'b0;
    prog_row = '0;
    col = '0;
    row = '0;
    t_fall = -100.0;
    foreach (arr[i]) arr[i] = 8'hFF;
    dreg = arr;
  end

  // Open-drain pull for the whole operation; a chip-select rise in
  // between is ignored, so only an FFh reset cuts an array read short
  task automatic go_busy(input int t);
    busy_pull = 1'b1;
    busy_cnt++;
    busy_t = t + slow_ns;
    fork
      #(busy_t) busy_pull = 1'b0;
    join_none
  endtask

  task automatic take_cmd(input logic [7:0] b);
    if (busy_pull && !(b inside {8'h70, 8'hF1, 8'hFF})) return;
    case (b)
      8'h00: begin na = 0; stat = 1'b0; end
      8'h60: na = 2;
      8'h05, 8'h85: na = 0;
      8'h30: begin stat = 1'b0; dreg = arr; go_busy(T_READ_NS); end
      8'h80: begin na = 0; loaded = 1'b0; pbuf = '{default: 8'hFF}; end
      8'h10: begin
        stat = 1'b1;
        if (loaded && pins.write_protect_n) begin
          // Same or lower page programmed again is counted
          if (progd && row <= prog_row) reprog++;
          progd = 1'b1;
          prog_row = row;
          arr = pbuf;
          go_busy(T_PROG_NS);
        end
      end
      8'h70, 8'hF1: stat = 1'b1;
      8'hFF: begin stat = 1'b0; busy_pull = 1'b0; end
      default: ;
    endcase
  endtask

  // Five address bytes: column low, column high, three row bytes
  task automatic take_addr(input logic [7:0] b);
    case (na)
      0: col[7:0] = b;
      1: col[12:8] = b[4:0];
      2: row[7:0] = b;
      3: row[15:8] = b;
      default: row[19:16] = b[3:0];
    endcase
    if ((na == 1 && b[7:5] != 0) || (na == 4 && b[7:4] != 0)) bad_hi++;
    na++;
  endtask

  // Bus cycles are taken on the write strobe rise, qualified by levels
  always @(posedge pins.write_strobe_n) begin
    if (!pins.chip_sel_n && pins.read_strobe_n) begin
      if (pins.cmd_latch && !pins.addr_latch) take_cmd(pins.io_bus);
      else if (pins.addr_latch && !pins.cmd_latch) take_addr(pins.io_bus);
      else if (!pins.cmd_latch && !pins.addr_latch && pins.write_protect_n
               && !busy_pull) begin
        pbuf[col[3:0]] = pins.io_bus;
        col = col + 1'b1;
        loaded = 1'b1;
      end
    end
  end

  // One byte per read strobe fall, column moves on except in status mode
  always @(negedge pins.read_strobe_n) begin
    if (!pins.chip_sel_n && pins.write_strobe_n && !pins.cmd_latch
        && !pins.addr_latch) begin
      if ($realtime - t_fall < 25.0) fast_re++;
      t_fall = $realtime;
      last = stat ? {1'b0, !busy_pull, 6'b00_0000} : dreg[col[3:0]];
      io_out = last;
      if (!stat) col = col + 1'b1;
    end
  end

  // Released bus shows the inverse, so a stale byte never passes
  always @(posedge pins.read_strobe_n) io_out = ~last;
endmodule
`default_nettype wire

// ---- nand_bus_cmd_read_program_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.svh"
`define CHK(nm, e, s) begin \
  tests_run++; \
  if ((s) !== (e)) begin \
    bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); \
  end \
end
module nand_bus_cmd_read_program_bench
  import nand_host_pkg::*;
;
  // ****************************************
  // Bus, pins and bookkeeping
  // ****************************************
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        busy_pull;
  logic [7:0]  io_in;
  nand_out_s   pins;
  wire logic   ready_line;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n0;
  typedef struct { logic [12:0] col; logic [7:0] exp; } row_s;
  row_s        rows [6] = '{'{13'h0000, 8'hA0}, '{13'h0003, 8'hA3},
    '{13'h0008, 8'h5A}, '{13'h0009, 8'h5B}, '{13'h0005, 8'hFF},
    '{13'h0001, 8'hA1}};
  logic [7:0]  reg_at  [6] = '{`REG_CTRL, `REG_COL, `REG_ROW, `REG_OP,
    `REG_STATUS, 8'h20};
  logic [31:0] reg_rst [6] = '{32'h0000_0002, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0700, 32'h0000_0002, 32'h0000_0000};

  // Open-drain ready line with its pull-up
  assign ready_line = busy_pull ? 1'b0 : 1'b1;

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  // Short array read limit keeps the run brief
  nand_host #(.ARRAY_READ_CYC(16'h00C8)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .io_bus_in(io_in),
    .ready_busy_n(ready_line));

  nand_mem_model #(.T_READ_NS(500), .T_PROG_NS(300)) mdl (
    .pins(pins), .io_out(io_in), .busy_pull(busy_pull));

  // ****************************************
  // Bus and operation tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    d = hrdata;
  endtask

  // Start one pin operation and poll until it is no longer busy
  task automatic op(input op_e k, input logic [7:0] b, input logic w);
    int n;
    bus_wr(`REG_OP, {19'h0_0000, w, 1'b0, k, b});
    @(posedge hclk);
    n = 0;
    do begin
      bus_rd(`REG_STATUS, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic goto(input logic [12:0] c, input logic [19:0] r);
    bus_wr(`REG_COL, {19'h0_0000, c});
    bus_wr(`REG_ROW, {12'h000, r});
  endtask

  task automatic rd_page();
    op(OP_CMD, 8'h00, 1'b0);
    op(OP_ADDR5, 8'h00, 1'b0);
    op(OP_CMD, 8'h30, 1'b1);
  endtask

  task automatic col_out(input logic [12:0] c);
    bus_wr(`REG_COL, {19'h0_0000, c});
    op(OP_CMD, 8'h05, 1'b0);
    op(OP_ADDR2, 8'h00, 1'b0);
    op(OP_CMD, 8'hE0, 1'b0);
    op(OP_DOUT, 8'h00, 1'b0);
    bus_rd(`REG_RDATA, rd);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge hclk);
    `CHK("cs in reset", 1'b1, pins.chip_sel_n)
    `CHK("wp in reset", 1'b0, pins.write_protect_n)
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (reg_at[i]) begin
      bus_rd(reg_at[i], rd);
      `CHK("reset register", reg_rst[i], rd)
    end
    // Program with a redirect in mid-load; gaps stay erased
    bus_wr(`REG_CTRL, 32'h0000_0001);
    goto(13'h0000, 20'h1_2345);
    op(OP_CMD, 8'h80, 1'b0);
    op(OP_ADDR5, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) op(OP_DIN, 8'hA0 + i[7:0], 1'b0);
    op(OP_CMD, 8'h85, 1'b0);
    op(OP_ADDR, 8'h08, 1'b0);
    op(OP_ADDR, 8'h00, 1'b0);
    op(OP_DIN, 8'h5A, 1'b0);
    op(OP_DIN, 8'h5B, 1'b0);
    op(OP_CMD, 8'h10, 1'b1);
    `CHK("status after program", 32'h0000_0002, rd)
    `CHK("busy count", 1, mdl.busy_cnt)
    `CHK("redirected byte", 8'h5B, mdl.arr[9])
    `CHK("row", 20'h1_2345, mdl.row)
    `CHK("upper address bits", 0, mdl.bad_hi)
    op(OP_DOUT, 8'h00, 1'b0);
    bus_rd(`REG_RDATA, rd);
    `CHK("status byte", 8'h40, rd[7:0])
    // Page read, then random column reads from the table
    bus_wr(`REG_COL, 32'h0000_0000);
    rd_page();
    `CHK("busy count", 2, mdl.busy_cnt)
    foreach (rows[i]) begin
      col_out(rows[i].col);
      `CHK("page byte", rows[i].exp, rd[7:0])
    end
    op(OP_DOUT, 8'h00, 1'b0);
    bus_rd(`REG_RDATA, rd);
    `CHK("next byte", 8'hA2, rd[7:0])
    // Protection raised before the confirm leaves the page alone
    op(OP_CMD, 8'h80, 1'b0);
    op(OP_ADDR5, 8'h00, 1'b0);
    op(OP_DIN, 8'h11, 1'b0);
    bus_wr(`REG_CTRL, 32'h0000_0000);
    op(OP_CMD, 8'h10, 1'b1);
    `CHK("wp pin", 1'b0, pins.write_protect_n)
    `CHK("protected byte", 8'hA0, mdl.arr[0])
    // Two planes, then output from one plane
    bus_wr(`REG_CTRL, 32'h0000_0001);
    for (int p = 0; p < 2; p++) begin
      op(OP_CMD, 8'h60, 1'b0);
      op(OP_ADDR3, 8'h00, 1'b0);
    end
    op(OP_CMD, 8'h30, 1'b1);
    `CHK("busy count", 3, mdl.busy_cnt)
    op(OP_CMD, 8'h00, 1'b0);
    op(OP_ADDR5, 8'h00, 1'b0);
    col_out(13'h0003);
    `CHK("plane byte", 8'hA3, rd[7:0])
    // Refused operation kind leaves the link idle
    bus_wr(`REG_OP, 32'h0000_0700);
    @(posedge hclk);
    bus_rd(`REG_STATUS, rd);
    `CHK("refused op", 32'h0000_0002, rd)
    // Slow array read runs past the limit
    mdl.slow_ns = 3000;
    rd_page();
    `CHK("timeout flag", 32'h0000_0008, rd)
    n0 = 0;
    while (ready_line !== 1'b1 && n0 < 2000) begin
      @(posedge hclk);
      n0++;
    end
    `CHK("ready back", 1'b1, ready_line)
    mdl.slow_ns = 0;
    op(OP_CMD, 8'h70, 1'b0);
    `CHK("timeout cleared", 32'h0000_0002, rd)
    // Deselect and wait out the standby time
    bus_wr(`REG_CTRL, 32'h0000_0003);
    repeat (1900) @(posedge hclk);
    bus_rd(`REG_STATUS, rd);
    `CHK("early standby", 32'h0000_0002, rd)
    repeat (200) @(posedge hclk);
    bus_rd(`REG_STATUS, rd);
    `CHK("standby", 32'h0000_0006, rd)
    `CHK("cs high", 1'b1, pins.chip_sel_n)
    `CHK("read strobe pace", 0, mdl.fast_re)
    `CHK("page order", 0, mdl.reprog)
    `CHK("response", 1'b0, hresp)
    give_verdict();
  end
endmodule
`default_nettype wire
